// >>> rtl/usb_init_cmd_pkg.sv
// Operation
// RQ1: D0h byte loads address and function enable
// RQ2: bus reset zeroes address, sets function enable
// RQ3: D8h bit 0 gates non-control endpoints
// RQ4: endpoints active only while function enabled
// RQ5: F3h bit 2 keeps clocks in suspend
// RQ6: host clears clock bit when bus powered
// RQ7: mode bits survive a bus reset
// RQ8: bit 3 enables NAK and error interrupts
// RQ9: bit 4 pull-up only with Vbus present
// RQ10: bits 7-6 select second pair mode
// RQ11: host writes fixed values to reserved bits
// RQ12: bit 7 second byte: SOF-only interrupt
// RQ13: FBh bit 5 adds SOF to interrupt
// RQ14: index four/five enables only in default
// RQ15: B0h-BFh bit 0 enables tied endpoint
// RQ16: bits 2-1 hold endpoint transfer type
// RQ17: bits 6-3 hold max packet size code
// RQ18: host writes zero to reserved bits
// RQ19: command byte then data, applied at end
package usb_init_cmd_pkg;

   // command codes
   localparam logic [7:0] CMD_SET_ADDRESS = 8'hD0;
   localparam logic [7:0] CMD_SET_ALL_ENDPOINTS_ENABLE = 8'hD8;
   localparam logic [7:0] CMD_SET_MODE = 8'hF3;
   localparam logic [7:0] CMD_SET_INTERRUPT = 8'hFB;
   localparam logic [7:0] CMD_EP_CONFIG_BASE = 8'hB0;
   localparam logic [3:0] CMD_EP_CONFIG_HIGH = 4'hB;

   localparam int NUM_EP_INDEX = 16;
   localparam int DEFAULT_EP_INDEX = 6;
   localparam logic [3:0] IDX_FOUR = 4'h4;
   localparam logic [3:0] IDX_FIVE = 4'h5;

   // field positions
   localparam int ADDR_ENABLE_BIT = 7;
   localparam int ALL_ENDPOINTS_ENABLE_BIT = 0;
   localparam int MODE_CLOCK_RUN_BIT = 2;
   localparam int MODE_NAK_IRQ_BIT = 3;
   localparam int MODE_PULLUP_BIT = 4;
   localparam int MODE_EP2_LSB = 6;
   localparam int MODE_SOF_ONLY_BIT = 7;
   localparam int INT_PIN_MODE_BIT = 5;
   localparam int INT_IDX_FOUR_BIT = 6;
   localparam int INT_IDX_FIVE_BIT = 7;
   localparam int EPC_ENABLE_BIT = 0;
   localparam int EPC_TYPE_LSB = 1;
   localparam int EPC_SIZE_LSB = 3;

   // values after reset
   localparam logic [6:0] ADDRESS_RESET = 7'h00;
   localparam logic [7:0] MODE_LOW_RESET = 8'h0C;
   localparam logic [7:0] MODE_HIGH_RESET = 8'h0B;
   localparam logic [7:0] INT_CONFIG_RESET = 8'h00;
   localparam logic [6:0] EP_CONFIG_RESET = 7'h00;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] first;
      logic [7:0] second;
   } cmd_write_s;

   typedef struct packed {
      logic [1:0] epType;
      logic [3:0] maxSize;
      logic enabled;
   } ep_config_s;

endpackage

// >>> rtl/cmd_byte_parser.sv
`timescale 1ns/10ps
`default_nettype none
module cmd_byte_parser
   import usb_init_cmd_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic reset, // synchronous reset
   input wire logic byteValid, // one byte this cycle
   input wire logic [7:0] byteData, // byte value
   input wire logic byteIsCommand, // byte is a command code
   output logic writeValid, // one-cycle write pulse
   output cmd_write_s writeCmd // collected command
);

   typedef enum {WAIT_CMD, WAIT_DATA} parse_state_e;

   parse_state_e state_r;
   logic [1:0] remaining_r;
   cmd_write_s collect_r;

   // data byte count owned by this block; zero means not ours
   function automatic logic [1:0] cmdLength(input logic [7:0] code);
      if (code == CMD_SET_MODE) return 2'd2;
      if (code == CMD_SET_ADDRESS || code == CMD_SET_ALL_ENDPOINTS_ENABLE || code == CMD_SET_INTERRUPT) return 2'd1;
      if (code[7:4] == CMD_EP_CONFIG_HIGH) return 2'd1;
      return 2'd0;
   endfunction

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= WAIT_CMD;
         remaining_r <= 2'd0;
         collect_r <= '0;
         writeValid <= 1'b0;
         writeCmd <= '0;
      end else begin
         writeValid <= 1'b0;
         if (byteValid && byteIsCommand) begin
            // a new command aborts any unfinished one
            collect_r.code <= byteData;
            remaining_r <= cmdLength(byteData);
            state_r <= (cmdLength(byteData) != 2'd0) ? WAIT_DATA : WAIT_CMD; // RQ19
         end else if (byteValid) begin
            case (state_r)
               WAIT_DATA: begin
                  if (remaining_r == 2'd2) begin
                     collect_r.first <= byteData;
                     remaining_r <= 2'd1;
                  end else begin
                     writeValid <= 1'b1; // RQ19
                     writeCmd <= (cmdLength(collect_r.code) == 2'd2) ?
                        {collect_r.code, collect_r.first, byteData} : {collect_r.code, byteData, 8'h00};
                     remaining_r <= 2'd0;
                     state_r <= WAIT_CMD;
                  end
               end
               default: state_r <= WAIT_CMD;
            endcase
         end
      end
   end

endmodule // cmd_byte_parser
`default_nettype wire

// >>> rtl/ep_config_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ep_config_mem
   import usb_init_cmd_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic reset, // synchronous reset
   input wire logic wrEn, // write strobe
   input wire logic [3:0] wrIndex, // endpoint index written
   input wire ep_config_s wrData, // new configuration
   input wire logic [3:0] rdIndex, // endpoint index read
   output ep_config_s rdData // registered read data
);

   ep_config_s mem_r [NUM_EP_INDEX];

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_EP_INDEX; i++) begin
            mem_r[i] <= EP_CONFIG_RESET;
         end
      end else if (wrEn) begin
         mem_r[wrIndex] <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdData <= EP_CONFIG_RESET;
      end else begin
         rdData <= mem_r[rdIndex];
      end
   end

endmodule // ep_config_mem
`default_nettype wire

// >>> rtl/usb_device_init_command_regs.sv
`timescale 1ns/10ps
`default_nettype none
module usb_device_init_command_regs
   import usb_init_cmd_pkg::*;
(
   input wire logic clk, // system clock, 100 MHz
   input wire logic reset, // synchronous reset, active high
   input wire logic byteValid, // serial byte received this cycle
   input wire logic [7:0] byteData, // received byte
   input wire logic byteIsCommand, // byte is in command phase
   input wire logic usbBusReset, // USB bus reset seen, level or pulse
   input wire logic enhancedMode, // enhanced command set active
   input wire logic vbusPresent, // Vbus detected
   input wire logic sofReceived, // one-cycle pulse per SOF packet
   input wire logic [15:0] endpointIrqPending, // interrupt register bits per endpoint index
   input wire logic deviceIrqPending, // bus reset or suspend change bit set
   input wire logic [3:0] epQueryIndex, // endpoint index to look up
   output logic [6:0] deviceAddress, // USB device address
   output logic functionEnable, // function enabled
   output logic allEndpointsEnable, // global endpoint enable
   output logic [15:0] endpointActive, // effective enable per endpoint index
   output logic clockRunInSuspend, // keep clocks during suspend
   output logic nakErrorIrqEnable, // interrupt on NAK and error transactions
   output logic connectResistorEnable, // DP pull-up drive
   output logic [1:0] secondEndpointPairMode, // second pair mode, default mode only
   output logic sofOnlyIrqMode, // interrupt on SOF only
   output logic irqPinSofMode, // interrupt pin also on SOF
   output logic indexFourIrqEnable, // effective index four interrupt enable
   output logic indexFiveIrqEnable, // effective index five interrupt enable
   output ep_config_s epQueryConfig, // configuration of queried index
   output logic interruptOut // interrupt pin, active high
);

   ////////////////////////////////////////////////////////////////////////////////
   // command intake

   logic writeValid;
   cmd_write_s writeCmd;

   cmd_byte_parser u_parser (
      .clk(clk),
      .reset(reset),
      .byteValid(byteValid),
      .byteData(byteData),
      .byteIsCommand(byteIsCommand),
      .writeValid(writeValid),
      .writeCmd(writeCmd)
   );

   logic wrAddress;
   logic wrEpEnable;
   logic wrMode;
   logic wrInterrupt;
   logic wrEpConfig;

   always_comb begin
      wrAddress = writeValid && (writeCmd.code == CMD_SET_ADDRESS);
      wrEpEnable = writeValid && (writeCmd.code == CMD_SET_ALL_ENDPOINTS_ENABLE);
      wrMode = writeValid && (writeCmd.code == CMD_SET_MODE);
      wrInterrupt = writeValid && (writeCmd.code == CMD_SET_INTERRUPT);
      // the per-endpoint commands only exist in the enhanced command set
      wrEpConfig = writeValid && enhancedMode && (writeCmd.code[7:4] == CMD_EP_CONFIG_HIGH); // RQ15
   end

   ////////////////////////////////////////////////////////////////////////////////
   // address and function enable

   logic [6:0] deviceAddress_r;
   logic functionEnable_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         deviceAddress_r <= ADDRESS_RESET;
      end else if (usbBusReset) begin
         // bus reset wins over a write landing in the same cycle
         deviceAddress_r <= ADDRESS_RESET; // RQ2
      end else if (wrAddress) begin
         deviceAddress_r <= writeCmd.first[6:0]; // RQ1
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         functionEnable_r <= 1'b0;
      end else if (usbBusReset) begin
         functionEnable_r <= 1'b1; // RQ2
      end else if (wrAddress) begin
         functionEnable_r <= writeCmd.first[ADDR_ENABLE_BIT]; // RQ1
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // global endpoint enable

   logic allEndpointsEnable_r;

   // reserved bits 7-1 are dropped, the host keeps them zero
   always_ff @(posedge clk) begin
      if (reset) begin
         allEndpointsEnable_r <= 1'b0;
      end else if (wrEpEnable) begin
         allEndpointsEnable_r <= writeCmd.first[ALL_ENDPOINTS_ENABLE_BIT]; // RQ3
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mode bytes; not touched by bus reset

   logic clockRun_r;
   logic nakIrq_r;
   logic pullup_r;
   logic [1:0] ep2Mode_r;
   logic sofOnly_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         clockRun_r <= MODE_LOW_RESET[MODE_CLOCK_RUN_BIT];
         nakIrq_r <= MODE_LOW_RESET[MODE_NAK_IRQ_BIT];
         pullup_r <= MODE_LOW_RESET[MODE_PULLUP_BIT];
         ep2Mode_r <= MODE_LOW_RESET[MODE_EP2_LSB +: 2];
      end else if (wrMode) begin
         // no bus reset term here: programmed values stay across it
         clockRun_r <= writeCmd.first[MODE_CLOCK_RUN_BIT]; // RQ5 RQ7
         nakIrq_r <= writeCmd.first[MODE_NAK_IRQ_BIT]; // RQ8 RQ7
         pullup_r <= writeCmd.first[MODE_PULLUP_BIT]; // RQ9 RQ7
         ep2Mode_r <= writeCmd.first[MODE_EP2_LSB +: 2]; // RQ10
      end
   end

   // second byte low bits and must_be_one_bit carry no function here
   always_ff @(posedge clk) begin
      if (reset) begin
         sofOnly_r <= MODE_HIGH_RESET[MODE_SOF_ONLY_BIT];
      end else if (wrMode) begin
         sofOnly_r <= writeCmd.second[MODE_SOF_ONLY_BIT]; // RQ12
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt configuration

   logic irqPinMode_r;
   logic idxFourIrq_r;
   logic idxFiveIrq_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         irqPinMode_r <= INT_CONFIG_RESET[INT_PIN_MODE_BIT];
         idxFourIrq_r <= INT_CONFIG_RESET[INT_IDX_FOUR_BIT];
         idxFiveIrq_r <= INT_CONFIG_RESET[INT_IDX_FIVE_BIT];
      end else if (wrInterrupt) begin
         irqPinMode_r <= writeCmd.first[INT_PIN_MODE_BIT]; // RQ13
         idxFourIrq_r <= writeCmd.first[INT_IDX_FOUR_BIT]; // RQ14
         idxFiveIrq_r <= writeCmd.first[INT_IDX_FIVE_BIT]; // RQ14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-endpoint configuration

   ep_config_s epWrData;
   logic [15:0] epEnableBits_r;

   always_comb begin
      epWrData.enabled = writeCmd.first[EPC_ENABLE_BIT]; // RQ15
      epWrData.epType = writeCmd.first[EPC_TYPE_LSB +: 2]; // RQ16
      epWrData.maxSize = writeCmd.first[EPC_SIZE_LSB +: 4]; // RQ17
   end

   ep_config_mem u_ep_mem (
      .clk(clk),
      .reset(reset),
      .wrEn(wrEpConfig),
      .wrIndex(writeCmd.code[3:0]),
      .wrData(epWrData),
      .rdIndex(epQueryIndex),
      .rdData(epQueryConfig)
   );

   // enable bits are mirrored so every index can be gated in one cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         epEnableBits_r <= 16'h0000;
      end else if (wrEpConfig) begin
         epEnableBits_r[writeCmd.code[3:0]] <= writeCmd.first[EPC_ENABLE_BIT]; // RQ15
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // effective endpoint enables

   logic [15:0] endpointActive_r;
   logic [15:0] activeNxt;

   always_comb begin
      activeNxt = 16'h0000;
      for (int i = 0; i < NUM_EP_INDEX; i++) begin
         if (i < 2) begin
            // control endpoint zero ignores the global bit
            activeNxt[i] = 1'b1; // RQ3
         end else begin
            activeNxt[i] = allEndpointsEnable_r; // RQ3
         end
         if (enhancedMode) begin
            activeNxt[i] = activeNxt[i] & epEnableBits_r[i]; // RQ15
         end else if (i >= DEFAULT_EP_INDEX) begin
            activeNxt[i] = 1'b0;
         end
         activeNxt[i] = activeNxt[i] & functionEnable_r; // RQ4
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         endpointActive_r <= 16'h0000;
      end else begin
         endpointActive_r <= activeNxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // derived control outputs

   logic connect_r;
   logic [1:0] ep2ModeOut_r;
   logic idxFourOut_r;
   logic idxFiveOut_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         connect_r <= 1'b0;
      end else begin
         connect_r <= pullup_r & vbusPresent; // RQ9
      end
   end

   // in enhanced mode the bits are reserved and read as non-iso
   always_ff @(posedge clk) begin
      if (reset) begin
         ep2ModeOut_r <= 2'b00;
      end else begin
         ep2ModeOut_r <= enhancedMode ? 2'b00 : ep2Mode_r; // RQ10
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         idxFourOut_r <= 1'b0;
         idxFiveOut_r <= 1'b0;
      end else begin
         idxFourOut_r <= enhancedMode | idxFourIrq_r; // RQ14
         idxFiveOut_r <= enhancedMode | idxFiveIrq_r; // RQ14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt pin

   logic [15:0] gatedIrq;
   logic anyIrq;
   logic interrupt_r;

   always_comb begin
      gatedIrq = endpointIrqPending;
      gatedIrq[IDX_FOUR] = endpointIrqPending[IDX_FOUR] & (enhancedMode | idxFourIrq_r); // RQ14
      gatedIrq[IDX_FIVE] = endpointIrqPending[IDX_FIVE] & (enhancedMode | idxFiveIrq_r); // RQ14
      anyIrq = (|gatedIrq) | deviceIrqPending;
   end

   // outside sof-only mode the pin follows the pending bits one cycle late; with the pin SOF bit set, SOF shows as a pulse
   always_ff @(posedge clk) begin
      if (reset) begin
         interrupt_r <= 1'b0;
      end else if (sofOnly_r) begin
         interrupt_r <= sofReceived; // RQ12
      end else begin
         interrupt_r <= anyIrq | (irqPinMode_r & sofReceived); // RQ13
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign deviceAddress = deviceAddress_r;
   assign functionEnable = functionEnable_r;
   assign allEndpointsEnable = allEndpointsEnable_r;
   assign endpointActive = endpointActive_r;
   assign clockRunInSuspend = clockRun_r;
   assign nakErrorIrqEnable = nakIrq_r;
   assign connectResistorEnable = connect_r;
   assign secondEndpointPairMode = ep2ModeOut_r;
   assign sofOnlyIrqMode = sofOnly_r;
   assign irqPinSofMode = irqPinMode_r;
   assign indexFourIrqEnable = idxFourOut_r;
   assign indexFiveIrqEnable = idxFiveOut_r;
   assign interruptOut = interrupt_r;

endmodule // usb_device_init_command_regs
`default_nettype wire

// >>> tb/regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module regs_checker (
   input wire logic clk, // clock
   input wire logic reset, // sync reset
   input wire logic usbBusReset, // bus reset
   input wire logic enhancedMode, // command set
   input wire logic vbusPresent, // vbus
   input wire logic sofReceived, // sof pulse
   input wire logic deviceIrqPending, // device irq
   input wire logic [6:0] deviceAddress, // address
   input wire logic functionEnable, // function
   input wire logic allEndpointsEnable, // global enable
   input wire logic [15:0] endpointActive, // per index
   input wire logic clockRunInSuspend, // clock bit
   input wire logic nakErrorIrqEnable, // nak bit
   input wire logic connectResistorEnable, // pull-up
   input wire logic [1:0] secondEndpointPairMode, // pair mode
   input wire logic sofOnlyIrqMode, // sof only
   input wire logic irqPinSofMode, // pin mode
   input wire logic indexFourIrqEnable, // index four
   input wire logic indexFiveIrqEnable, // index five
   input wire logic interruptOut // irq pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   bus_reset_addr_a: assert property (usbBusReset |-> ##[1:2] (deviceAddress == 7'h00 && functionEnable))
      else $error("bus reset left address or enable");
   mode_retained_a: assert property (usbBusReset |=>
      $stable({clockRunInSuspend, nakErrorIrqEnable, connectResistorEnable, irqPinSofMode}))
      else $error("mode bits changed by bus reset");
   ep_zero_on_a: assert property (!$past(enhancedMode) |-> endpointActive[0] == $past(functionEnable))
      else $error("endpoint zero not following function");
   func_gates_a: assert property (|endpointActive |-> $past(functionEnable))
      else $error("endpoint active while function off");
   global_gates_a: assert property (|endpointActive[15:2] |-> $past(allEndpointsEnable))
      else $error("endpoint active without global enable");
   pullup_vbus_a: assert property (connectResistorEnable |-> $past(vbusPresent))
      else $error("pull-up without vbus");
   pair_mode_rsv_a: assert property ($past(enhancedMode) |-> secondEndpointPairMode == 2'b00)
      else $error("pair mode set in enhanced mode");
   idx_always_a: assert property (!$past(reset) && $past(enhancedMode) |-> indexFourIrqEnable && indexFiveIrqEnable)
      else $error("index irq gated in enhanced mode");
   sof_only_a: assert property (sofOnlyIrqMode |=> interruptOut == $past(sofReceived))
      else $error("sof-only irq mismatch");
   pending_irq_a: assert property (!sofOnlyIrqMode && deviceIrqPending |=> interruptOut)
      else $error("pending bit gave no irq");
endmodule // regs_checker
`default_nettype wire

// >>> tb/cmd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmd_host_model
   import usb_init_cmd_pkg::*;
(
   input wire logic clk, // system clock
   output logic byteValid, // byte strobe
   output logic [7:0] byteData, // byte value
   output logic byteIsCommand // command phase
);
   initial begin
      byteValid = 1'b0;
      byteData = 8'h00;
      byteIsCommand = 1'b0;
   end
   task automatic sendByte(input logic isCmd, input logic [7:0] b);
      @(posedge clk);
      byteValid <= 1'b1;
      byteIsCommand <= isCmd;
      byteData <= b;
   endtask
   // idle data shows the inverted last byte so stale data never looks valid
   task automatic goIdle();
      @(posedge clk);
      byteValid <= 1'b0;
      byteIsCommand <= 1'b0;
      byteData <= ~byteData;
   endtask
   task automatic sendCmd(input logic [7:0] code, input logic [7:0] d1, input logic [7:0] d2);
      logic [7:0] b;
      b = d1;
      if (code == CMD_SET_MODE) b = d1 & 8'hDC;
      if (code == CMD_SET_ALL_ENDPOINTS_ENABLE) b = {7'h00, d1[0]};
      if (code == CMD_SET_INTERRUPT) b = {d1[7:5], 5'h00};
      if (code[7:4] == CMD_EP_CONFIG_HIGH) b = {1'b0, d1[6:0]};
      sendByte(1'b1, code);
      sendByte(1'b0, b);
      if (code == CMD_SET_MODE) sendByte(1'b0, {d2[7], 7'h4F});
      goIdle();
   endtask
endmodule // cmd_host_model
`default_nettype wire

// >>> tb/usb_device_init_command_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module usb_device_init_command_regs_bench
   import usb_init_cmd_pkg::*;
;
   logic clk, reset, byteValid, byteIsCommand, usbBusReset, enhancedMode, vbusPresent, sofReceived;
   logic deviceIrqPending, functionEnable, allEndpointsEnable, clockRunInSuspend, nakErrorIrqEnable;
   logic connectResistorEnable, sofOnlyIrqMode, irqPinSofMode, indexFourIrqEnable, indexFiveIrqEnable;
   logic interruptOut;
   logic [7:0] byteData;
   logic [15:0] endpointIrqPending, endpointActive;
   logic [3:0] epQueryIndex;
   logic [6:0] deviceAddress;
   logic [1:0] secondEndpointPairMode;
   ep_config_s epQueryConfig;
   int fails = 0;
   int n_checks = 0;
   typedef struct packed {
      logic [7:0] code;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [17:0] obs;
      logic [15:0] act;
   } row_s;
   // obs = {fe, address, global, clock, nak, pull-up, pair mode, sof only, pin sof, idx4, idx5}
   row_s rows [12] = '{'{8'hD0, 8'h85, 8'h00, 18'h21580, 16'h0003}, '{8'hD0, 8'h7F, 8'h00, 18'h1FD80, 16'h0000},
      '{8'hD0, 8'hFF, 8'h00, 18'h3FD80, 16'h0003}, '{8'hD8, 8'h01, 8'h00, 18'h3FF80, 16'h003F},
      '{8'hF3, 8'hD0, 8'h00, 18'h3FE70, 16'h003F}, '{8'hF3, 8'h4C, 8'h80, 18'h3FF98, 16'h003F},
      '{8'hF3, 8'h8C, 8'h00, 18'h3FFA0, 16'h003F}, '{8'hFB, 8'hE0, 8'h00, 18'h3FFA7, 16'h003F},
      '{8'hFB, 8'h40, 8'h00, 18'h3FFA2, 16'h003F}, '{8'hFB, 8'h80, 8'h00, 18'h3FFA1, 16'h003F},
      '{8'hF3, 8'h1C, 8'h00, 18'h3FFC1, 16'h003F}, '{8'hD8, 8'h00, 8'h00, 18'h3FDC1, 16'h0003}};
   usb_device_init_command_regs dut (.clk(clk), .reset(reset), .byteValid(byteValid), .byteData(byteData),
      .byteIsCommand(byteIsCommand), .usbBusReset(usbBusReset), .enhancedMode(enhancedMode),
      .vbusPresent(vbusPresent), .sofReceived(sofReceived), .endpointIrqPending(endpointIrqPending),
      .deviceIrqPending(deviceIrqPending), .epQueryIndex(epQueryIndex), .deviceAddress(deviceAddress),
      .functionEnable(functionEnable), .allEndpointsEnable(allEndpointsEnable), .endpointActive(endpointActive),
      .clockRunInSuspend(clockRunInSuspend), .nakErrorIrqEnable(nakErrorIrqEnable),
      .connectResistorEnable(connectResistorEnable), .secondEndpointPairMode(secondEndpointPairMode),
      .sofOnlyIrqMode(sofOnlyIrqMode), .irqPinSofMode(irqPinSofMode), .indexFourIrqEnable(indexFourIrqEnable),
      .indexFiveIrqEnable(indexFiveIrqEnable), .epQueryConfig(epQueryConfig), .interruptOut(interruptOut));
   cmd_host_model host (.clk(clk), .byteValid(byteValid), .byteData(byteData), .byteIsCommand(byteIsCommand));
   function automatic logic [17:0] obs();
      return {functionEnable, deviceAddress, allEndpointsEnable, clockRunInSuspend, nakErrorIrqEnable,
         connectResistorEnable, secondEndpointPairMode, sofOnlyIrqMode, irqPinSofMode, indexFourIrqEnable,
         indexFiveIrqEnable};
   endfunction
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic sofPulse();
      @(posedge clk) sofReceived <= 1'b1;
      @(posedge clk) sofReceived <= 1'b0;
      #1;
   endtask
   // query index changes need one edge to reach the registered read port
   task automatic query(input logic [3:0] idx, input logic [6:0] ex);
      @(posedge clk) epQueryIndex <= idx;
      settle(2);
      `CHK("epQueryConfig", ex, epQueryConfig);
   endtask
   task print_verdict();
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #1000000;
      fails++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset, usbBusReset, enhancedMode, vbusPresent, sofReceived, deviceIrqPending} = 6'b000100;
      reset = 1'b1;
      endpointIrqPending = 16'h0000;
      epQueryIndex = 4'h0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      #1;
      `CHK("resetObs", 18'h00180, obs());
      `CHK("resetIrq", 1'b0, interruptOut);
      `CHK("resetAct", 16'h0000, endpointActive);
      for (int i = 0; i < 12; i++) begin
         host.sendCmd(rows[i].code, rows[i].d1, rows[i].d2);
         settle(4);
         `CHK("rowObs", rows[i].obs, obs());
         `CHK("rowAct", rows[i].act, endpointActive);
      end
      // aborted D0h, unknown code and a default-mode config write leave state alone; the D8h write sets the global enable
      host.sendByte(1'b1, 8'hD0);
      host.sendByte(1'b1, 8'hD8);
      host.sendByte(1'b0, 8'h01);
      host.sendByte(1'b1, 8'h12);
      host.sendByte(1'b0, 8'h55);
      host.goIdle();
      host.sendCmd(8'hBF, 8'h01, 8'h00);
      settle(4);
      `CHK("abortObs", 18'h3FFC1, obs());
      @(posedge clk) usbBusReset <= 1'b1;
      @(posedge clk) usbBusReset <= 1'b0;
      settle(3);
      `CHK("busRstObs", 18'h203C1, obs());
      @(posedge clk) vbusPresent <= 1'b0;
      settle(2);
      `CHK("noVbus", 1'b0, connectResistorEnable);
      @(posedge clk) vbusPresent <= 1'b1;
      settle(2);
      `CHK("vbusBack", 1'b1, connectResistorEnable);
      ////////////////////////////////////////////////////////////////////////////////////////////////
      host.sendCmd(8'hFB, 8'h00, 8'h00);
      @(posedge clk) endpointIrqPending <= 16'h0010;
      settle(2);
      `CHK("idx4Gated", 1'b0, interruptOut);
      host.sendCmd(8'hFB, 8'h40, 8'h00);
      settle(4);
      `CHK("idx4Open", 1'b1, interruptOut);
      @(posedge clk) endpointIrqPending <= 16'h0000;
      settle(2);
      sofPulse();
      `CHK("sofPinOff", 1'b0, interruptOut);
      host.sendCmd(8'hFB, 8'h20, 8'h00);
      settle(4);
      sofPulse();
      `CHK("sofPinOn", 1'b1, interruptOut);
      host.sendCmd(8'hF3, 8'h1C, 8'h80);
      @(posedge clk) deviceIrqPending <= 1'b1;
      settle(4);
      `CHK("sofOnlyIdle", 1'b0, interruptOut);
      sofPulse();
      `CHK("sofOnlyHit", 1'b1, interruptOut);
      // leaving sof-only mode with the device bit still pending must raise the pin
      host.sendCmd(8'hF3, 8'h1C, 8'h00);
      settle(4);
      `CHK("devIrq", 1'b1, interruptOut);
      @(posedge clk) deviceIrqPending <= 1'b0;
      ////////////////////////////////////////////////////////////////////////////////////////////////
      @(posedge clk) enhancedMode <= 1'b1;
      query(4'hF, 7'h00);
      host.sendCmd(8'hB4, 8'h0B, 8'h00);
      host.sendCmd(8'hB5, 8'h7C, 8'h00);
      host.sendCmd(8'hBF, 8'h03, 8'h00);
      host.sendCmd(8'hF3, 8'hDC, 8'h00);
      settle(4);
      `CHK("epAct", 3'b101, {endpointActive[15], endpointActive[5], endpointActive[4]});
      `CHK("enhModes", 4'b0011, {secondEndpointPairMode, indexFourIrqEnable, indexFiveIrqEnable});
      query(4'h4, 7'h23);
      query(4'h5, 7'h5E);
      query(4'hF, 7'h21);
      @(posedge clk) endpointIrqPending <= 16'h0010;
      settle(2);
      `CHK("enhIdx4", 1'b1, interruptOut);
      print_verdict();
   end
endmodule // usb_device_init_command_regs_bench
bind usb_device_init_command_regs regs_checker chk (.clk(clk), .reset(reset), .usbBusReset(usbBusReset),
   .enhancedMode(enhancedMode), .vbusPresent(vbusPresent), .sofReceived(sofReceived),
   .deviceIrqPending(deviceIrqPending), .deviceAddress(deviceAddress), .functionEnable(functionEnable),
   .allEndpointsEnable(allEndpointsEnable), .endpointActive(endpointActive), .clockRunInSuspend(clockRunInSuspend),
   .nakErrorIrqEnable(nakErrorIrqEnable), .connectResistorEnable(connectResistorEnable),
   .secondEndpointPairMode(secondEndpointPairMode), .sofOnlyIrqMode(sofOnlyIrqMode), .irqPinSofMode(irqPinSofMode),
   .indexFourIrqEnable(indexFourIrqEnable), .indexFiveIrqEnable(indexFiveIrqEnable), .interruptOut(interruptOut));
`default_nettype wire
